// ===== rtl/fcdq_top.sv
`timescale 1ns/100ps
`include "fcdq_regs.svh"

// Behaviour
// RULE1 - Level comparator is low below the threshold; one pulse per carrier cycle above it.
// RULE2 - Carrier present rises only in receive mode after four consecutive pulses.
// RULE3 - Carrier present holds while receiving and pulse gaps stay under 2.5 ms.
// RULE4 - After carrier drops, a fresh run of four pulses from zero is needed.
// RULE5 - Four pulses equal four carrier periods: 3.33 ms at 1200 Hz, 1.82 ms at 2200.
// RULE6 - The system supplies the modem time base from a resonator or external clock.
// RULE7 - Power-on clear is held low past 2.5 V supply plus 10 ns.
// RULE8 - Received data shows only with carrier present: high for 1200 Hz, low for 2200.
// RULE9 - Send request low means transmit with modulator on; high means receive.
// RULE10 - Power-on clear low holds carrier low and clears counter and timer.

module fcdq_top #(
  parameter logic [17:0] GAP_TIMEOUT_CYCLES = 18'(`FCDQ_GAP_TIMEOUT_CYCLES),
  parameter logic [17:0] SPLIT_HALF_CYCLES = 18'(`FCDQ_SPLIT_HALF_CYCLES)
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic signed [7:0] filtered_rx_level,
  input wire logic signed [7:0] detect_threshold_ref,
  input wire logic send_request_n,
  input wire logic power_on_clear_n,
  output logic carrier_present,
  output logic rx_bit_out,
  output logic modulator_enable
);

  // ==========================================================
  // Helpers

  // Saturating increment, shared by the gap timer and the half period counter
  function automatic fcdq_pkg::fcdq_count_t fcdq_sat_inc(input fcdq_pkg::fcdq_count_t value);
    if (value == 18'h3FFFF) begin
      fcdq_sat_inc = value;
    end else begin
      fcdq_sat_inc = value + 18'h00001;
    end
  endfunction : fcdq_sat_inc

  // ==========================================================
  // Pin synchronisers

  // Bit 0 is send request, bit 1 is power-on clear; both idle high
  logic [1:0] pin_raw;
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic [1:0] pin_s3;
  logic [1:0] pin_stable;
  logic [1:0] next_pin_stable;

  assign pin_raw = {power_on_clear_n, send_request_n};

  // A change counts only once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      always_comb begin
        next_pin_stable[gi] = (pin_s2[gi] == pin_s3[gi]) ? pin_s3[gi] : pin_stable[gi];
      end
    end
  endgenerate

  // Power-on clear resets to low so the block stays cleared until the pin shows high
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_s1 <= `FCDQ_PIN_SYNC_RST;
      pin_s2 <= `FCDQ_PIN_SYNC_RST;
      pin_s3 <= `FCDQ_PIN_SYNC_RST;
      pin_stable <= `FCDQ_PIN_SYNC_RST;
    end else if (ce) begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_stable <= next_pin_stable;
    end
  end

  logic receive_mode;
  logic clear_n;

  assign receive_mode = pin_stable[0]; // RULE9
  assign clear_n = pin_stable[1];

  // Modulator runs only while the host asks to send
  assign modulator_enable = ~pin_stable[0]; // RULE9

  // ==========================================================
  // Comparators

  // Samples arrive from logic on this clock, so no synchroniser
  logic level_above;
  logic level_above_q;
  logic zero_above;
  logic zero_above_q;
  logic carrier_pulse;
  logic zero_cross;

  // Below the threshold the comparator is low
  assign level_above = (filtered_rx_level >= detect_threshold_ref); // RULE1
  // One rising edge per carrier cycle gives one pulse
  assign carrier_pulse = level_above & ~level_above_q; // RULE1 RULE5
  // Data comparator sits on analog ground and toggles each crossing
  assign zero_above = (filtered_rx_level > 8'sh00);
  assign zero_cross = zero_above ^ zero_above_q;

  // Previous comparator levels for edge detection
  always_ff @(posedge clock) begin
    if (rst) begin
      level_above_q <= 1'b0;
      zero_above_q <= 1'b0;
    end else if (ce) begin
      level_above_q <= level_above;
      zero_above_q <= zero_above;
    end
  end

  // ==========================================================
  // Carrier qualification

  fcdq_pkg::fcdq_state_t state;
  fcdq_pkg::fcdq_state_t next_state;
  logic [2:0] pulse_cnt;
  logic [2:0] next_pulse_cnt;
  fcdq_pkg::fcdq_count_t gap_timer;
  fcdq_pkg::fcdq_count_t next_gap_timer;
  logic gap_expired;

  // A pulse landing exactly on the expiry is late and starts a new run
  assign gap_expired = (gap_timer == GAP_TIMEOUT_CYCLES - 18'h00001); // RULE3

  // Next state, pulse count and gap timer
  always_comb begin
    next_state = state;
    next_pulse_cnt = pulse_cnt;
    next_gap_timer = gap_timer;
    if (!clear_n || !receive_mode) begin
      // Cleared or transmitting: nothing is qualified
      next_state = fcdq_pkg::FCDQ_QUALIFY; // RULE10 RULE2 RULE3
      next_pulse_cnt = `FCDQ_PULSE_CNT_RST; // RULE10
      next_gap_timer = `FCDQ_TIMER_RST; // RULE10
    end else begin
      next_gap_timer = carrier_pulse ? `FCDQ_TIMER_RST : fcdq_sat_inc(gap_timer);
      if (gap_expired) begin
        // Carrier lost; a pulse arriving now counts as the first of a new run
        next_state = fcdq_pkg::FCDQ_QUALIFY; // RULE3
        next_pulse_cnt = carrier_pulse ? 3'h1 : `FCDQ_PULSE_CNT_RST; // RULE4
      end else if (carrier_pulse) begin
        unique case (state)
          fcdq_pkg::FCDQ_QUALIFY: begin
            if (pulse_cnt == `FCDQ_PULSES_NEEDED - 3'h1) begin
              next_state = fcdq_pkg::FCDQ_PRESENT; // RULE2 RULE5
              next_pulse_cnt = `FCDQ_PULSE_CNT_RST; // RULE4
            end else begin
              next_pulse_cnt = pulse_cnt + 3'h1; // RULE2
            end
          end
          fcdq_pkg::FCDQ_PRESENT: begin
            next_state = fcdq_pkg::FCDQ_PRESENT; // RULE3
          end
        endcase
      end
    end
  end

  // Detector registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= fcdq_pkg::FCDQ_QUALIFY;
      pulse_cnt <= `FCDQ_PULSE_CNT_RST;
      gap_timer <= `FCDQ_TIMER_RST;
    end else if (ce) begin
      state <= next_state;
      pulse_cnt <= next_pulse_cnt;
      gap_timer <= next_gap_timer;
    end
  end

  assign carrier_present = (state == fcdq_pkg::FCDQ_PRESENT); // RULE2 RULE3

  // ==========================================================
  // Demodulator

  // Half period length decides mark or space; crude but enough for two tones
  fcdq_pkg::fcdq_count_t half_cnt;
  fcdq_pkg::fcdq_count_t next_half_cnt;
  logic demod_bit;
  logic next_demod_bit;
  logic rx_bit;
  logic next_rx_bit;

  // Next half period count, decision and gated output bit
  always_comb begin
    next_half_cnt = fcdq_sat_inc(half_cnt);
    next_demod_bit = demod_bit;
    if (!clear_n || !receive_mode) begin
      // Receive path is off while transmitting
      next_half_cnt = `FCDQ_TIMER_RST;
      next_demod_bit = 1'b0;
    end else if (zero_cross) begin
      // Long half period is mark, short is space
      next_demod_bit = (half_cnt >= SPLIT_HALF_CYCLES); // RULE8
      next_half_cnt = `FCDQ_TIMER_RST;
    end
    // Data passes only with a qualified carrier
    next_rx_bit = next_demod_bit & (next_state == fcdq_pkg::FCDQ_PRESENT); // RULE8
  end

  // Demodulator registers
  always_ff @(posedge clock) begin
    if (rst) begin
      half_cnt <= `FCDQ_TIMER_RST;
      demod_bit <= 1'b0;
      rx_bit <= 1'b0;
    end else if (ce) begin
      half_cnt <= next_half_cnt;
      demod_bit <= next_demod_bit;
      rx_bit <= next_rx_bit;
    end
  end

  assign rx_bit_out = rx_bit;

endmodule : fcdq_top

// ===== rtl/fcdq_regs.svh
`ifndef FCDQ_REGS_SVH
`define FCDQ_REGS_SVH

// ==========================================================
// Clock
`define FCDQ_CLK_PERIOD_NS 10

// ==========================================================
// Carrier qualification
`define FCDQ_PULSES_NEEDED 3'h4
`define FCDQ_PULSE_CNT_RST 3'h0

// Longest gap between comparator pulses, as a time
`define FCDQ_GAP_TIMEOUT_NS 2500000
// Longest gap as a count, rounded down
`define FCDQ_GAP_TIMEOUT_CYCLES (`FCDQ_GAP_TIMEOUT_NS / `FCDQ_CLK_PERIOD_NS)

// ==========================================================
// Demodulator split between mark and space half periods
// Mark half period 417 us, space 227 us, split near the middle
`define FCDQ_SPLIT_HALF_NS 294000
`define FCDQ_SPLIT_HALF_CYCLES (`FCDQ_SPLIT_HALF_NS / `FCDQ_CLK_PERIOD_NS)

// ==========================================================
// Reset values
`define FCDQ_TIMER_RST 18'h00000
`define FCDQ_PIN_SYNC_RST 2'h1

`endif

// ===== rtl/fcdq_pkg.sv
// ==========================================================
// Types shared by the carrier detect qualifier
package fcdq_pkg;

  // Detector states
  typedef enum logic {
    FCDQ_QUALIFY,
    FCDQ_PRESENT
  } fcdq_state_t;

  // Width of the gap and half period counters
  typedef logic [17:0] fcdq_count_t;

endpackage : fcdq_pkg

// ===== verification/fcdq_host.sv
`timescale 1ns/100ps
// ==========
// Host pins
module fcdq_host (
  input wire logic tx,
  input wire logic clr,
  output logic send_request_n,
  output logic power_on_clear_n
);
  // Both pins active low; bench moves them on falling edges only
  assign send_request_n = !tx;
  assign power_on_clear_n = !clr;
endmodule : fcdq_host

// ===== verification/fcdq_checker.sv
`timescale 1ns/100ps
// ==========
// Port checker
module fcdq_checker #(
  parameter logic [17:0] GAP_TIMEOUT_CYCLES = 18'h00040,
  parameter logic [17:0] SPLIT_HALF_CYCLES = 18'h00010
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic signed [7:0] filtered_rx_level,
  input wire logic signed [7:0] detect_threshold_ref,
  input wire logic send_request_n,
  input wire logic power_on_clear_n,
  input wire logic carrier_present,
  input wire logic rx_bit_out,
  input wire logic modulator_enable
);
  logic above;
  logic above_d;
  logic pos;
  logic [17:0] gap;
  logic [17:0] next_gap;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Cycles since last pulse; saturates so long idles never wrap
  assign above = filtered_rx_level >= detect_threshold_ref;
  assign pos = filtered_rx_level > 8'sh00;
  always_comb begin
    next_gap = (above && !above_d) ? 18'h00000 : gap + 18'(gap != 18'h3FFFF);
  end
  always_ff @(posedge clock) begin
    above_d <= rst ? 1'b1 : above;
    gap <= rst ? 18'h00000 : next_gap;
  end
  a_rx_gated: assert property (!carrier_present |-> !rx_bit_out) else $error("data without carrier");
  a_mod_follow: assert property ($fell(send_request_n) |-> ##[3:5] modulator_enable)
    else $error("modulator late");
  a_tx_quiet: assert property (modulator_enable [*2] |-> !carrier_present) else $error("carrier in tx");
  a_clear_low: assert property (!power_on_clear_n [*7] |-> !carrier_present) else $error("carrier in clear");
  a_rise_pulse: assert property ($rose(carrier_present) |-> $past(above) && !$past(above, 2))
    else $error("rise without pulse");
  // Drop falls exactly on the edge where the gap reaches the limit
  a_drop_late: assert property ($fell(carrier_present) && !modulator_enable && power_on_clear_n
    |-> $past(gap) + 18'h00001 >= GAP_TIMEOUT_CYCLES) else $error("carrier dropped early");
  a_drop_due: assert property (gap == GAP_TIMEOUT_CYCLES |-> !carrier_present)
    else $error("carrier held too long");
  a_mod_release: assert property ($rose(send_request_n) |-> ##[3:5] !modulator_enable)
    else $error("modulator stays on");
  a_rx_cross: assert property ($changed(rx_bit_out) && $past(carrier_present) && carrier_present
    |-> $past(pos) != $past(pos, 2)) else $error("bit moved off crossing");
endmodule : fcdq_checker

bind fcdq_top fcdq_checker #(
  .GAP_TIMEOUT_CYCLES(GAP_TIMEOUT_CYCLES),
  .SPLIT_HALF_CYCLES(SPLIT_HALF_CYCLES)
) chk (
  .clock(clock),
  .rst(rst),
  .ce(ce),
  .filtered_rx_level(filtered_rx_level),
  .detect_threshold_ref(detect_threshold_ref),
  .send_request_n(send_request_n),
  .power_on_clear_n(power_on_clear_n),
  .carrier_present(carrier_present),
  .rx_bit_out(rx_bit_out),
  .modulator_enable(modulator_enable)
);

// ===== verification/testbench.sv
`timescale 1ns/100ps
// ==========
// Bench top
module testbench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic tx = 1'b0;
  logic clr = 1'b1;
  logic signed [7:0] lvl = 8'shC0;
  logic signed [7:0] ref_lvl = 8'sh20;
  logic send_request_n;
  logic power_on_clear_n;
  logic carrier_present;
  logic rx_bit_out;
  logic modulator_enable;
  int failures = 0;
  int tests_run = 0;
  // Fast clock stands in for the modem time base
  always #5 clock = ~clock;
  fcdq_host host (.tx(tx), .clr(clr), .send_request_n(send_request_n), .power_on_clear_n(power_on_clear_n));
  // Short gap and split keep the run brief
  fcdq_top #(.GAP_TIMEOUT_CYCLES(18'h00040), .SPLIT_HALF_CYCLES(18'h00010)) dut (.clock(clock), .rst(rst),
    .ce(1'b1), .filtered_rx_level(lvl), .detect_threshold_ref(ref_lvl), .send_request_n(send_request_n),
    .power_on_clear_n(power_on_clear_n), .carrier_present(carrier_present), .rx_bit_out(rx_bit_out),
    .modulator_enable(modulator_enable));
  task automatic chk(input string nm, input logic e, input logic s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %b seen %b", nm, e, s);
    end
  endtask : chk
  // Square wave of h cycles a half; one comparator pulse a period
  task automatic wave(input int n, input int h);
    repeat (n) begin
      lvl = 8'sh40;
      repeat (h) @(negedge clock);
      lvl = 8'shC0;
      repeat (h) @(negedge clock);
    end
  endtask : wave
  task automatic t_qualify;
    wave(3, 20);
    chk("carrier", 1'b0, carrier_present);
    wave(1, 20);
    chk("carrier", 1'b1, carrier_present);
    chk("rx_bit", 1'b1, rx_bit_out);
    wave(4, 10);
    chk("carrier", 1'b1, carrier_present);
    chk("rx_bit", 1'b0, rx_bit_out);
    repeat (70) @(negedge clock);
    chk("carrier", 1'b0, carrier_present);
    $display("qualify done");
  endtask : t_qualify
  task automatic t_restart;
    wave(2, 20);
    repeat (70) @(negedge clock);
    wave(3, 20);
    chk("carrier", 1'b0, carrier_present);
    wave(1, 20);
    chk("carrier", 1'b1, carrier_present);
    $display("restart done");
  endtask : t_restart
  task automatic t_tx;
    tx = 1'b1;
    repeat (8) @(negedge clock);
    chk("modulator", 1'b1, modulator_enable);
    wave(5, 20);
    chk("carrier", 1'b0, carrier_present);
    tx = 1'b0;
    repeat (8) @(negedge clock);
    chk("modulator", 1'b0, modulator_enable);
    wave(4, 20);
    chk("carrier", 1'b1, carrier_present);
    $display("transmit done");
  endtask : t_tx
  task automatic t_clear;
    clr = 1'b1;
    repeat (10) @(negedge clock);
    chk("carrier", 1'b0, carrier_present);
    clr = 1'b0;
    repeat (8) @(negedge clock);
    wave(3, 20);
    chk("carrier", 1'b0, carrier_present);
    $display("clear done");
  endtask : t_clear
  // Peaks under the threshold give no pulses; equal to it counts as above
  task automatic t_weak;
    ref_lvl = 8'sh50;
    wave(6, 20);
    chk("carrier", 1'b0, carrier_present);
    chk("rx_bit", 1'b0, rx_bit_out);
    ref_lvl = 8'sh40;
    wave(4, 20);
    chk("carrier", 1'b1, carrier_present);
    ref_lvl = 8'sh20;
    $display("threshold done");
  endtask : t_weak
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  // Clear pin stays low through start-up
  initial begin
    repeat (6) @(negedge clock);
    rst = 1'b0;
    clr = 1'b0;
    repeat (8) @(negedge clock);
    t_qualify;
    t_restart;
    t_tx;
    t_clear;
    t_weak;
    tally_and_finish;
  end
  // Watchdog, several times the expected run
  initial begin
    #100000;
    failures++;
    tally_and_finish;
  end
endmodule : testbench
